/* File: logic/tsr_pkg.sv */
package tsr_pkg;
    // register addresses
    localparam logic [6:0] ADDR_TEMP_CONTROL_STATUS = 7'h4e;
    localparam logic [6:0] ADDR_TEMP_RESULT         = 7'h4f;
    localparam logic [6:0] ADDR_FRONT_END_SENS      = 7'h58;
    localparam logic [6:0] ADDR_REF_SOURCE_SELECT   = 7'h59;
    localparam logic [6:0] ADDR_SYNTH_LOOP_BW       = 7'h5f;
    localparam logic [6:0] ADDR_FADING_MARGIN       = 7'h6f;
    localparam logic [6:0] ADDR_LOW_INDEX_OFFSET    = 7'h71;
    // field positions
    localparam int TRIGGER_BIT  = 3;
    localparam int BUSY_BIT     = 2;
    localparam int EXT_REF_BIT  = 4;
    // reset values and named setting codes
    localparam logic [1:0] TEMP_CS_LOW_RST     = 2'h1;
    localparam logic [7:0] FRONT_END_RST       = 8'h1b;
    localparam logic [7:0] FRONT_END_HIGH_SENS = 8'h2d;
    localparam logic [7:0] REF_SOURCE_RST      = 8'h09;
    localparam logic [7:0] SYNTH_LOOP_BW_RST   = 8'h08;
    localparam logic [7:0] FADING_MARGIN_RST   = 8'h30;
    localparam logic [7:0] FADING_NORMAL       = 8'h00;
    localparam logic [7:0] LOW_INDEX_RST       = 8'h00;
    localparam logic [7:0] TEMP_RESULT_RST     = 8'h00;
    // offset step in hertz per lsb
    localparam int OFFSET_STEP_HZ = 488;
    // timing
    localparam int CLK_HZ         = 40000000;
    localparam int CONV_TIME_US   = 100;
    localparam int CONV_CYCLES    = (CONV_TIME_US * (CLK_HZ / 1000000));
    localparam int POR_TIME_US    = 10;
    localparam int POR_CYCLES     = (POR_TIME_US * (CLK_HZ / 1000000));
    localparam int REFERENCE_CLOCK_OUTPUT_DIV     = 2;
endpackage

/* File: logic/tsr_reg_if.sv */
`timescale 1ns/1ps
interface tsr_reg_if;
    logic       wrEn;
    logic       rdEn;
    logic [6:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport core (output wrEn, output rdEn, output addr, output wrData, input rdData);
    modport bank (input wrEn, input rdEn, input addr, input wrData, output rdData);
endinterface

/* File: logic/tsr_reg_bank.sv */
`timescale 1ns/1ps
module tsr_reg_bank (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // access
    tsr_reg_if.bank   bus,
    // live state
    input  wire logic       busy,
    input  wire logic [7:0] thermal,
    // configuration out
    output logic [7:0] frontEndGainSelect,
    output logic [7:0] refSel,
    output logic [7:0] synthBw,
    output logic [7:0] fadingMarginCtrl,
    output logic [7:0] lowIndexFreqOffset
);
    logic [7:0] next_frontEndGainSelect;
    logic [7:0] next_refSel;
    logic [7:0] next_synthBw;
    logic [7:0] next_fadingMarginCtrl;
    logic [7:0] next_lowIndexFreqOffset;
    logic [7:0] next_rdData;

    always_comb begin
        next_frontEndGainSelect = frontEndGainSelect;
        next_refSel             = refSel;
        next_synthBw            = synthBw;
        next_fadingMarginCtrl   = fadingMarginCtrl;
        next_lowIndexFreqOffset = lowIndexFreqOffset;
        if (bus.wrEn) begin
            case (bus.addr)
                tsr_pkg::ADDR_FRONT_END_SENS:    next_frontEndGainSelect = bus.wrData;
                tsr_pkg::ADDR_REF_SOURCE_SELECT: next_refSel = bus.wrData;
                tsr_pkg::ADDR_SYNTH_LOOP_BW:     next_synthBw = bus.wrData;
                tsr_pkg::ADDR_FADING_MARGIN:     next_fadingMarginCtrl = bus.wrData;
                tsr_pkg::ADDR_LOW_INDEX_OFFSET:  next_lowIndexFreqOffset = bus.wrData;
                default: ;
            endcase
        end
        // read data holds between reads
        next_rdData = bus.rdData;
        if (bus.rdEn) begin
            case (bus.addr)
                // trigger bit always reads zero
                tsr_pkg::ADDR_TEMP_CONTROL_STATUS: next_rdData = {5'h00, busy, tsr_pkg::TEMP_CS_LOW_RST};
                tsr_pkg::ADDR_TEMP_RESULT:         next_rdData = thermal;
                tsr_pkg::ADDR_FRONT_END_SENS:      next_rdData = frontEndGainSelect;
                tsr_pkg::ADDR_REF_SOURCE_SELECT:   next_rdData = refSel;
                tsr_pkg::ADDR_SYNTH_LOOP_BW:       next_rdData = synthBw;
                tsr_pkg::ADDR_FADING_MARGIN:       next_rdData = fadingMarginCtrl;
                tsr_pkg::ADDR_LOW_INDEX_OFFSET:    next_rdData = lowIndexFreqOffset;
                default:                           next_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frontEndGainSelect <= tsr_pkg::FRONT_END_RST;
            refSel             <= tsr_pkg::REF_SOURCE_RST;
            synthBw            <= tsr_pkg::SYNTH_LOOP_BW_RST;
            fadingMarginCtrl   <= tsr_pkg::FADING_MARGIN_RST;
            lowIndexFreqOffset <= tsr_pkg::LOW_INDEX_RST;
            bus.rdData         <= 8'h00;
        end else begin
            frontEndGainSelect <= next_frontEndGainSelect;
            refSel             <= next_refSel;
            synthBw            <= next_synthBw;
            fadingMarginCtrl   <= next_fadingMarginCtrl;
            lowIndexFreqOffset <= next_lowIndexFreqOffset;
            bus.rdData         <= next_rdData;
        end
    end
endmodule

/* File: logic/tsr_temp_sensor_regs.sv */
`timescale 1ns/1ps
// Functional notes
// - writing trigger starts conversion; reads zero
// - busy high whole conversion, then clears
// - receiver unavailable while conversion runs
// - result read-only, minus one degree per lsb
// - sensitivity 0x1b normal, 0x2d high
// - reference select: crystal or external sine
// - fading margin 0x00, 0x20, 0x30; reset 0x30
// - offset equals register times 488 Hz
// - internal power-on reset, independent of pin
module tsr_temp_sensor_regs #(
    parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES,
    parameter int POR_CYCLES  = tsr_pkg::POR_CYCLES
) (
    // clock and resets
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        manualReset,
    // register access
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [6:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output logic [7:0]       regRdData,
    // sensor
    input  wire logic [7:0]  sensorSample,
    // controls to the receiver
    output logic             conversionBusyFlag,
    output logic             rxEnable,
    output logic             deviceReady,
    output logic             referenceClockOutput,
    output logic             highSensitivity,
    output logic             externalReferenceSelect,
    output logic [7:0]       fadingMarginCtrl,
    output logic [7:0]       lowIndexFreqOffset,
    output logic [7:0]       synthLoopBandwidth,
    output logic [16:0]      offsetHz
);
    // sequencer states
    typedef enum logic [1:0] {
        ST_POR  = 2'b00,
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } tsr_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    tsr_reg_if regs ();
    logic [7:0] frontEnd;
    logic [7:0] refSel;
    logic [7:0] thermalReading;
    tsr_state_e state;
    tsr_state_e next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic [7:0]  next_thermalReading;
    logic        conversionTrigger;
    logic        coreRst;
    logic        porDone;
    logic        next_porDone;
    logic        next_conversionBusyFlag;
    logic        next_rxEnable;
    logic        next_deviceReady;
    logic        next_highSensitivity;
    logic        next_externalReferenceSelect;
    logic [16:0] next_offsetHz;
    logic        next_referenceClockOutput;
    // clock-out divider state
    logic [7:0]  divCount;
    logic [7:0]  next_divCount;
    logic        clkOutTick;
    logic        next_clkOutTick;

    // settle and conversion counters both end on the same compare
    function automatic logic countDone(input logic [31:0] value, input int limit);
        return value >= 32'(limit - 1);
    endfunction

    // pin and power-on reset both clear the core; power-on is rst itself
    assign coreRst = rst | manualReset;
    // writes are dropped until the settle count ends; reads always answer
    assign regs.wrEn   = regWrite & porDone;
    assign regs.rdEn   = regRead;
    assign regs.addr   = regAddr;
    assign regs.wrData = regWrData;
    assign conversionTrigger = regs.wrEn && regAddr == tsr_pkg::ADDR_TEMP_CONTROL_STATUS
                               && regWrData[tsr_pkg::TRIGGER_BIT];

    tsr_reg_bank tsr_reg_bank_i (
        .clk                (clk),
        .rst                (coreRst),
        .bus                (regs.bank),
        .busy               (state == ST_CONV),
        .thermal            (thermalReading),
        .frontEndGainSelect (frontEnd),
        .refSel             (refSel),
        .synthBw            (synthLoopBandwidth),
        .fadingMarginCtrl   (fadingMarginCtrl),
        .lowIndexFreqOffset (lowIndexFreqOffset)
    );
    assign regRdData = regs.rdData;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion sequencer; busy is visible the cycle after the trigger write
    always_comb begin
        next_state          = state;
        next_count          = count;
        next_thermalReading = thermalReading;
        next_porDone        = porDone;
        case (state)
            ST_POR: begin
                // writes ignored until the settle count runs out
                if (countDone(count, POR_CYCLES)) begin
                    next_state   = ST_IDLE;
                    next_porDone = 1'b1;
                    next_count   = 32'h0;
                end else begin
                    next_count = count + 32'h1;
                end
            end
            ST_IDLE: begin
                if (conversionTrigger) begin
                    next_state = ST_CONV;
                    next_count = 32'h0;
                end
            end
            ST_CONV: begin
                if (countDone(count, CONV_CYCLES)) begin
                    next_state          = ST_IDLE;
                    next_thermalReading = sensorSample;
                    next_count          = 32'h0;
                end else begin
                    next_count = count + 32'h1;
                end
            end
            default: begin
                next_state = ST_POR;
                next_count = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge coreRst) begin
        if (coreRst) begin
            state          <= ST_POR;
            count          <= 32'h0;
            thermalReading <= tsr_pkg::TEMP_RESULT_RST;
            porDone        <= 1'b0;
        end else begin
            state          <= next_state;
            count          <= next_count;
            thermalReading <= next_thermalReading;
            porDone        <= next_porDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock-out divider; a one-cycle tick enables the toggle, no second clock exists
    always_comb begin
        next_divCount   = divCount;
        next_clkOutTick = 1'b0;
        if (!porDone) begin
            // held at zero until settle ends, so the output cannot move early
            next_divCount = 8'h00;
        end else if (divCount >= 8'(tsr_pkg::REFERENCE_CLOCK_OUTPUT_DIV - 1)) begin
            next_divCount   = 8'h00;
            next_clkOutTick = 1'b1;
        end else begin
            next_divCount = divCount + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge coreRst) begin
        if (coreRst) begin
            divCount   <= 8'h00;
            clkOutTick <= 1'b0;
        end else begin
            divCount   <= next_divCount;
            clkOutTick <= next_clkOutTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered outputs; status follows next_state so it agrees with the register view
    always_comb begin
        next_conversionBusyFlag      = next_state == ST_CONV;
        next_rxEnable                = next_state == ST_IDLE;
        next_deviceReady             = next_porDone;
        // toggles on the tick only, so any activity implies ready
        next_referenceClockOutput    = clkOutTick ? ~referenceClockOutput : referenceClockOutput;
        next_highSensitivity         = frontEnd == tsr_pkg::FRONT_END_HIGH_SENS;
        next_externalReferenceSelect = refSel[tsr_pkg::EXT_REF_BIT];
        next_offsetHz                = 17'(lowIndexFreqOffset * tsr_pkg::OFFSET_STEP_HZ);
    end

    always_ff @(posedge clk or posedge coreRst) begin
        if (coreRst) begin
            conversionBusyFlag      <= 1'b0;
            rxEnable                <= 1'b0;
            deviceReady             <= 1'b0;
            referenceClockOutput    <= 1'b0;
            highSensitivity         <= 1'b0;
            externalReferenceSelect <= 1'b0;
            offsetHz                <= 17'h0;
        end else begin
            conversionBusyFlag      <= next_conversionBusyFlag;
            rxEnable                <= next_rxEnable;
            deviceReady             <= next_deviceReady;
            referenceClockOutput    <= next_referenceClockOutput;
            highSensitivity         <= next_highSensitivity;
            externalReferenceSelect <= next_externalReferenceSelect;
            offsetHz                <= next_offsetHz;
        end
    end
endmodule

/* File: testbench/tsr_temp_sensor_regs_properties.sv */
`timescale 1ns/1ps
module tsr_temp_sensor_regs_properties #(
    parameter int CONV_CYCLES = 8
) (
    // clock and resets
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        manualReset,
    // register access
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [6:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    // watched outputs
    input wire logic [7:0]  lowIndexFreqOffset,
    input wire logic        conversionBusyFlag,
    input wire logic        rxEnable,
    input wire logic        deviceReady,
    input wire logic        referenceClockOutput,
    input wire logic        highSensitivity,
    input wire logic [16:0] offsetHz
);
    logic [15:0] busyLen;
    always_ff @(posedge clk or posedge rst or posedge manualReset) begin
        if (rst || manualReset) busyLen <= 16'h0000;
        else busyLen <= conversionBusyFlag ? busyLen + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst || manualReset);
    sequence trigWrite;
        regWrite && regAddr == 7'h4e && regWrData[3] && deviceReady && !conversionBusyFlag;
    endsequence
    trig_start_a: assert property (trigWrite |=> conversionBusyFlag && !rxEnable) else $error("no start");
    busy_len_a: assert property ($fell(conversionBusyFlag) |-> busyLen == 16'(CONV_CYCLES))
        else $error("busy length off");
    rx_busy_a: assert property (conversionBusyFlag |-> !rxEnable) else $error("rx while busy");
    rd_fixed_a: assert property (regRead && regAddr == 7'h4e |=> regRdData[7:3] == 5'h00 && regRdData[1:0] == 2'h1)
        else $error("status fixed bits");
    rd_busy_a: assert property (regRead && regAddr == 7'h4e && conversionBusyFlag |=> regRdData[2])
        else $error("busy not read");
    hs_map_a: assert property (regWrite && deviceReady && regAddr == 7'h58 && regWrData == 8'h2d |-> ##[1:2] highSensitivity)
        else $error("sensitivity map");
    offset_scale_a: assert property ($stable(lowIndexFreqOffset)[*2] |-> offsetHz == 17'(lowIndexFreqOffset) * 17'd488)
        else $error("offset scale");
    ready_quiet_a: assert property (!deviceReady |-> !rxEnable && !referenceClockOutput)
        else $error("early activity");
endmodule

/* File: testbench/tsr_host_model.sv */
`timescale 1ns/1ps
module tsr_host_model #(
    parameter int         PULSE_CYCLES = 40,
    parameter logic [7:0] SAMPLE       = 8'ha7
) (
    // clock
    input  wire logic       clk,
    // pulse request from the test
    input  wire logic       pulseReq,
    // pins into the block
    output logic            manualReset,
    output logic [7:0]      sensorSample
);
    int cnt = 0;
    // pin sits at its released level unless a pulse is running
    assign manualReset  = cnt != 0;
    assign sensorSample = SAMPLE;
    always @(posedge clk) begin
        if (pulseReq && cnt == 0) begin
            cnt <= PULSE_CYCLES;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* File: testbench/tb_tsr_temp_sensor_regs.sv */
`timescale 1ns/1ps
module tb_tsr_temp_sensor_regs;
    logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, pulseReq = 1'b0;
    logic [6:0]  regAddr = 7'h00;
    logic [7:0]  regWrData = 8'h00, regRdData, sensorSample, fading, offReg, synthBw;
    logic        manualReset, busy, rxEnable, ready, reference_clock_output, highSens, extRef, prev;
    logic [16:0] offsetHz;
    logic [6:0]  ra [8] = '{7'h4e, 7'h4f, 7'h58, 7'h59, 7'h6f, 7'h71, 7'h00, 7'h5f};
    logic [7:0]  rv [8] = '{8'h01, 8'h00, 8'h1b, 8'h09, 8'h30, 8'h00, 8'h00, 8'h08};
    logic [7:0]  fm [3] = '{8'h00, 8'h20, 8'h30};
    int          error_cnt = 0;
    int          checks_done = 0;
    always #12.5 clk = ~clk;
    tsr_temp_sensor_regs #(.CONV_CYCLES(8), .POR_CYCLES(4)) tsr_temp_sensor_regs_i (
        .clk(clk), .rst(rst), .manualReset(manualReset), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .sensorSample(sensorSample),
        .conversionBusyFlag(busy), .rxEnable(rxEnable), .deviceReady(ready), .referenceClockOutput(reference_clock_output),
        .highSensitivity(highSens), .externalReferenceSelect(extRef), .fadingMarginCtrl(fading),
        .lowIndexFreqOffset(offReg), .synthLoopBandwidth(synthBw), .offsetHz(offsetHz));
    tsr_host_model tsr_host_model_i (.clk(clk), .pulseReq(pulseReq), .manualReset(manualReset),
        .sensorSample(sensorSample));
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rc(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(17'(regRdData), 17'(e));
    endtask
    task automatic waitReady();
        for (int i = 0; i < 80 && ready !== 1'b1; i++) @(posedge clk);
        #1;
        chk(17'(ready), 17'h1);
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // lands before the settle count ends, so it must be dropped
        wr(7'h58, 8'h2d);
        waitReady();
        for (int i = 0; i < 8; i++) rc(ra[i], rv[i]);
        chk(17'(synthBw), 17'h08);
        chk(17'(highSens), 17'h0);
        wr(7'h58, 8'h2d);
        wr(7'h59, 8'h10);
        wr(7'h71, 8'hff);
        repeat (2) @(posedge clk);
        #1;
        chk(17'(highSens), 17'h1);
        chk(17'(extRef), 17'h1);
        chk(offsetHz, 17'h1e618);
        chk(17'(offReg), 17'h0ff);
        wr(7'h5f, 8'h0c);
        rc(7'h5f, 8'h0c);
        chk(17'(synthBw), 17'h0c);
        for (int i = 0; i < 3; i++) begin
            wr(7'h6f, fm[i]);
            rc(7'h6f, fm[i]);
            chk(17'(fading), 17'(fm[i]));
        end
        wr(7'h4e, 8'h08);
        rc(7'h4e, 8'h05);
        chk(17'(rxEnable), 17'h0);
        chk(17'(busy), 17'h1);
        for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge clk);
        rc(7'h4e, 8'h01);
        rc(7'h4f, 8'ha7);
        wr(7'h4f, 8'h11);
        rc(7'h4f, 8'ha7);
        chk(17'(rxEnable), 17'h1);
        prev = reference_clock_output;
        repeat (2) @(posedge clk);
        #1;
        chk(17'(reference_clock_output ^ prev), 17'h1);
        @(posedge clk);
        pulseReq <= 1'b1;
        @(posedge clk);
        pulseReq <= 1'b0;
        #1;
        chk(17'(ready), 17'h0);
        waitReady();
        rc(7'h6f, 8'h30);
        rc(7'h58, 8'h1b);
        give_verdict();
    end
endmodule
bind tsr_temp_sensor_regs tsr_temp_sensor_regs_properties #(.CONV_CYCLES(CONV_CYCLES)) tsr_props_i (
    .clk(clk), .rst(rst), .manualReset(manualReset), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .lowIndexFreqOffset(lowIndexFreqOffset),
    .conversionBusyFlag(conversionBusyFlag), .rxEnable(rxEnable), .deviceReady(deviceReady),
    .referenceClockOutput(referenceClockOutput), .highSensitivity(highSensitivity), .offsetHz(offsetHz));
